// ---- inc/sbtc_pkg.sv ----
// Purpose: shared constants for the sixteen bit timer/counter
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: register indices are kept as printed; byte address is four times the index
package sbtc_pkg;

	function automatic logic [11:0] sbtc_addr(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction

	// ----------------------------------------
	// register indices and byte addresses
	// ----------------------------------------
	localparam logic [9:0] SBTC_IDX_FLAG = 10'h00C;
	localparam logic [9:0] SBTC_IDX_ENABLE = 10'h08C;
	localparam logic [9:0] SBTC_IDX_COUNT_LO = 10'h00E;
	localparam logic [9:0] SBTC_IDX_COUNT_HI = 10'h00F;
	localparam logic [9:0] SBTC_IDX_CTRL = 10'h010;
	localparam logic [11:0] SBTC_ADDR_FLAG = sbtc_addr(SBTC_IDX_FLAG);
	localparam logic [11:0] SBTC_ADDR_ENABLE = sbtc_addr(SBTC_IDX_ENABLE);
	localparam logic [11:0] SBTC_ADDR_COUNT_LO = sbtc_addr(SBTC_IDX_COUNT_LO);
	localparam logic [11:0] SBTC_ADDR_COUNT_HI = sbtc_addr(SBTC_IDX_COUNT_HI);
	localparam logic [11:0] SBTC_ADDR_CTRL = sbtc_addr(SBTC_IDX_CTRL);

	// ----------------------------------------
	// control field positions and reset values
	// ----------------------------------------
	localparam int SBTC_BIT_ON = 0;
	localparam int SBTC_BIT_CS = 1;
	localparam int SBTC_BIT_SYNC = 2;
	localparam int SBTC_BIT_OSCEN = 3;
	localparam int SBTC_BIT_PS_LO = 4;
	localparam int SBTC_BIT_PS_HI = 5;
	localparam int SBTC_BIT_OVF = 0;
	localparam logic [5:0] SBTC_CTRL_RESET = 6'h00;
	localparam logic [15:0] SBTC_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] SBTC_COUNT_ZERO = 16'h0000;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SBTC_INSTR_DIV = 4;
	localparam logic [1:0] SBTC_INSTR_LAST = 2'(SBTC_INSTR_DIV - 1);

	typedef enum logic [1:0] {
		SBTC_ARM_IDLE = 2'b00,
		SBTC_ARM_WAIT_FALL = 2'b01,
		SBTC_ARM_READY = 2'b10
	} sbtc_arm_t;

endpackage

// ---- inc/sbtc_presc_if.sv ----
// Purpose: link between the counter core and its prescaler
// Assumes: one clock domain
// Notes: tick is combinational from the prescaler
`timescale 1ns/1ps
interface sbtc_presc_if;
	logic clear;
	logic [1:0] ratio;
	logic edge_in;
	logic tick;
	modport core (output clear, output ratio, output edge_in, input tick);
	modport presc (input clear, input ratio, input edge_in, output tick);
endinterface

// ---- rtl/sbtc_prescaler.sv ----
// Purpose: 1/2/4/8 input prescaler
// Assumes: edge_in is a one-cycle pulse per input edge
// Notes: clear has priority over counting
`timescale 1ns/1ps
module sbtc_prescaler
	import sbtc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	sbtc_presc_if.presc pif
);

	logic [2:0] cnt_reg;
	logic [2:0] limit;

	function automatic logic [2:0] ratio_limit(input logic [1:0] r);
		return 3'((4'h1 << r) - 4'h1);
	endfunction

	assign limit = ratio_limit(pif.ratio);
	// R7: divide 1 2 4 8
	assign pif.tick = pif.edge_in && !pif.clear && (cnt_reg >= limit);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 3'h0;
		// R24: write clears prescaler
		end else if (pif.clear) begin
			cnt_reg <= 3'h0;
		end else if (pif.edge_in) begin
			cnt_reg <= (cnt_reg >= limit) ? 3'h0 : cnt_reg + 3'h1;
		end
	end

	AST_PRESC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		pif.clear |=> cnt_reg == 3'h0) // R24
		else $error("prescaler not cleared by count write");
	AST_PRESC_RATIO: assert property (@(posedge pclk) disable iff (!presetn)
		pif.tick |-> cnt_reg == limit) // R7
		else $error("prescaler tick at wrong count");

endmodule

// ---- rtl/sbtc_top.sv ----
// Purpose: sixteen bit timer/counter with APB register access
// Assumes: pins are synchronous to pclk; presetn stands for power-on/brown-out reset
// Notes: count bytes have no reset; a single clock models the asynchronous mode
`timescale 1ns/1ps
// Behaviour
// R1: count upward through 0000 to FFFF and wrap back to zero.
// R2: overflow latches flag bit 0; interrupt only when enable bit 0 is set.
// R3: source select 0 counts instruction cycles, 1 counts external rising edges.
// R4: on bit 1 runs counter, 0 stops and holds value.
// R5: capture/compare unit has an input that clears the count.
// R6: crystal enable forces both oscillator pins to inputs, ignoring direction bits.
// R7: prescale field 00,01,10,11 divides by 1,2,4,8.
// R8: control bits 7 and 6 always read zero.
// R9: external source: sync bit 1 bypasses synchroniser; ignored for internal source.
// R10: crystal enable turns the oscillator inverter on, clear shuts it off.
// R11: after enable in counter mode, rising edges ignored until first falling edge.
// R12: counter mode uses oscillator input pin if crystal enabled, else clock pin.
// R13: synchronised mode puts prescaler ahead of the synchroniser stage.
// R14: synchronised counter mode in sleep: count holds, prescaler keeps counting.
// R15: asynchronous mode counts in sleep; enabled overflow wakes the processor.
// R16: asynchronous mode count is no capture/compare time base.
// R17: reads of either count byte always return a valid value.
// R18: software should stop counter before writing count in asynchronous mode.
// R19: software reading two bytes must allow for overflow between reads.
// R20: crystal oscillator up to 200 kHz, mainly 32 kHz, runs during sleep.
// R21: software waits for oscillator start-up before relying on it.
// R22: compare trigger clears count without flag; simultaneous count write wins.
// R23: control clears on reset; count bytes are never reset.
// R24: any count byte write clears the prescaler.
// R25: compare trigger reset may fail in asynchronous counter mode.
// R26: flag sticky until software clears; control write leaves count alone.
module sbtc_top
	import sbtc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clock_pin_in,
	input wire logic osc_input_pin_in,
	output logic osc_input_pin_out,
	output logic osc_input_pin_oe,
	output logic osc_output_pin_out,
	output logic osc_output_pin_oe,
	input wire logic [1:0] port_c_data,
	input wire logic [1:0] port_c_direction,
	output logic osc_inverter_en,
	input wire logic sleep_mode,
	input wire logic special_event_trig,
	output logic overflow_irq,
	output logic wake_request,
	output logic timebase_valid,
	output logic [15:0] timebase_count
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [5:0] ctrl_reg;
	logic overflow_flag_reg;
	logic overflow_irq_enable_reg;
	logic [15:0] count_reg;
	logic [1:0] count_known_reg;
	logic [1:0] div_reg;
	logic pin_d_reg;
	logic sync_stage_reg;
	logic [31:0] rdata_reg;
	logic pin_in_oe_reg;
	logic pin_out_oe_reg;
	logic [1:0] pin_data_reg;
	sbtc_arm_t arm_reg;
	sbtc_arm_t arm_next;

	logic counter_on;
	logic clock_source_select;
	logic sync_bypass;
	logic crystal_osc_enable;
	logic [1:0] prescale_select;
	logic async_mode;
	logic instr_tick;
	logic sel_pin;
	logic pin_rise;
	logic pin_fall;
	logic ext_rise_ok;
	logic advance;
	logic wr_access;
	logic setup_phase;
	logic wr_lo;
	logic wr_hi;
	logic count_wr;
	logic trig_clear;
	logic ovf_event;
	logic mapped;

	sbtc_presc_if pif ();

	assign counter_on = ctrl_reg[SBTC_BIT_ON];
	assign clock_source_select = ctrl_reg[SBTC_BIT_CS];
	assign sync_bypass = ctrl_reg[SBTC_BIT_SYNC];
	assign crystal_osc_enable = ctrl_reg[SBTC_BIT_OSCEN];
	assign prescale_select = ctrl_reg[SBTC_BIT_PS_HI:SBTC_BIT_PS_LO];
	// R9: bypass only meaningful for external source
	assign async_mode = clock_source_select && sync_bypass;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign pready = 1'b1;
	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign wr_lo = wr_access && (paddr == SBTC_ADDR_COUNT_LO);
	assign wr_hi = wr_access && (paddr == SBTC_ADDR_COUNT_HI);
	assign count_wr = wr_lo || wr_hi;
	assign mapped = (paddr == SBTC_ADDR_FLAG) || (paddr == SBTC_ADDR_ENABLE) ||
		(paddr == SBTC_ADDR_COUNT_LO) || (paddr == SBTC_ADDR_COUNT_HI) ||
		(paddr == SBTC_ADDR_CTRL);
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_reg;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// R23: control clears on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= SBTC_CTRL_RESET;
		// R8: upper bits not stored
		end else if (wr_access && (paddr == SBTC_ADDR_CTRL)) begin
			ctrl_reg <= pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_irq_enable_reg <= 1'b0;
		end else if (wr_access && (paddr == SBTC_ADDR_ENABLE)) begin
			overflow_irq_enable_reg <= pwdata[SBTC_BIT_OVF];
		end
	end

	// R26: sticky flag, set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_reg <= 1'b0;
		end else if (wr_access && (paddr == SBTC_ADDR_FLAG)) begin
			overflow_flag_reg <= pwdata[SBTC_BIT_OVF] | ovf_event;
		end else if (ovf_event) begin
			overflow_flag_reg <= 1'b1;
		end
	end

	// R17: snapshot taken in setup, stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			case (paddr)
				SBTC_ADDR_FLAG: rdata_reg <= {31'h00000000, overflow_flag_reg};
				SBTC_ADDR_ENABLE: rdata_reg <= {31'h00000000, overflow_irq_enable_reg};
				SBTC_ADDR_COUNT_LO: rdata_reg <= {24'h000000, count_reg[7:0]};
				SBTC_ADDR_COUNT_HI: rdata_reg <= {24'h000000, count_reg[15:8]};
				// R8: bits 7 and 6 read zero
				SBTC_ADDR_CTRL: rdata_reg <= {26'h0000000, ctrl_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// clock sources
	// ----------------------------------------
	// R3: instruction cycle is pclk divided by four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
		end
	end
	assign instr_tick = (div_reg == SBTC_INSTR_LAST);

	// R12: pick count pin
	assign sel_pin = crystal_osc_enable ? osc_input_pin_in : ext_clock_pin_in;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_d_reg <= 1'b0;
		end else begin
			pin_d_reg <= sel_pin;
		end
	end
	assign pin_rise = sel_pin && !pin_d_reg;
	assign pin_fall = !sel_pin && pin_d_reg;

	// R11: arm on first falling edge
	always_comb begin
		arm_next = arm_reg;
		case (arm_reg)
			SBTC_ARM_IDLE: begin
				if (counter_on && clock_source_select) begin
					arm_next = SBTC_ARM_WAIT_FALL;
				end
			end
			SBTC_ARM_WAIT_FALL: begin
				if (!(counter_on && clock_source_select)) begin
					arm_next = SBTC_ARM_IDLE;
				end else if (pin_fall) begin
					arm_next = SBTC_ARM_READY;
				end
			end
			SBTC_ARM_READY: begin
				if (!(counter_on && clock_source_select)) begin
					arm_next = SBTC_ARM_IDLE;
				end
			end
			default: arm_next = SBTC_ARM_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_reg <= SBTC_ARM_IDLE;
		end else begin
			arm_reg <= arm_next;
		end
	end
	assign ext_rise_ok = (arm_reg == SBTC_ARM_READY) && pin_rise;

	// ----------------------------------------
	// prescaler and synchroniser stage
	// ----------------------------------------
	// R14: prescaler sees edges even in sleep; instruction clock stops in sleep
	assign pif.edge_in = counter_on &&
		(clock_source_select ? ext_rise_ok : (instr_tick && !sleep_mode));
	assign pif.ratio = prescale_select;
	assign pif.clear = count_wr;

	sbtc_prescaler u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.pif(pif)
	);

	// R13: sync stage after prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_stage_reg <= 1'b0;
		end else begin
			sync_stage_reg <= pif.tick && !async_mode;
		end
	end

	// R4: on bit gates advance
	// R14: synchroniser off in sleep
	// R15: asynchronous path keeps counting in sleep
	assign advance = counter_on &&
		(async_mode ? pif.tick : (sync_stage_reg && !sleep_mode));

	// ----------------------------------------
	// sixteen bit count
	// ----------------------------------------
	// R5: compare unit clear input
	assign trig_clear = special_event_trig && !count_wr;
	// R1: overflow when all ones advance
	assign ovf_event = advance && !count_wr && !trig_clear && (count_reg == SBTC_COUNT_MAX);

	// R23: count never reset
	always_ff @(posedge pclk) begin
		// R22: write wins over trigger
		// R18: write on an increment just overrides it
		if (wr_lo) begin
			count_reg[7:0] <= pwdata[7:0];
		end else if (wr_hi) begin
			count_reg[15:8] <= pwdata[7:0];
		// R22: trigger clears, flag untouched
		end else if (trig_clear) begin
			count_reg <= SBTC_COUNT_ZERO;
		// R1: wraps through zero
		end else if (advance) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_known_reg <= 2'h0;
		end else begin
			count_known_reg <= count_known_reg | {wr_hi || trig_clear, wr_lo || trig_clear};
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// R2: irq gated by enable
	assign overflow_irq = overflow_flag_reg && overflow_irq_enable_reg;
	// R15: wake only from asynchronous mode
	assign wake_request = overflow_irq && sleep_mode && async_mode;
	// R16: no time base in asynchronous mode
	assign timebase_valid = (&count_known_reg) && !async_mode;
	assign timebase_count = (&count_known_reg) ? count_reg : SBTC_COUNT_ZERO;
	// R10: inverter follows crystal enable
	// R20: not gated by sleep so the crystal keeps running
	assign osc_inverter_en = crystal_osc_enable;

	// R6: crystal enable overrides direction bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_in_oe_reg <= 1'b0;
			pin_out_oe_reg <= 1'b0;
			pin_data_reg <= 2'h0;
		end else begin
			pin_in_oe_reg <= !crystal_osc_enable && !port_c_direction[1];
			pin_out_oe_reg <= !crystal_osc_enable && !port_c_direction[0];
			pin_data_reg <= port_c_data;
		end
	end
	assign osc_input_pin_oe = pin_in_oe_reg;
	assign osc_output_pin_oe = pin_out_oe_reg;
	assign osc_input_pin_out = pin_data_reg[1];
	assign osc_output_pin_out = pin_data_reg[0];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_WRAP: assert property (ovf_event |=> count_reg == SBTC_COUNT_ZERO) // R1
		else $error("count did not wrap to zero");
	AST_INCR: assert property (advance && !count_wr && !trig_clear
		|=> count_reg == $past(count_reg) + 16'h0001) // R1
		else $error("count did not advance by one");
	AST_FLAG_SET: assert property (ovf_event |=> overflow_flag_reg [*2]) // R2
		else $error("overflow flag not latched");
	AST_IRQ_GATE: assert property (overflow_irq |-> overflow_irq_enable_reg) // R2
		else $error("interrupt without enable");
	AST_OFF_HOLD: assert property ((&count_known_reg) && !counter_on && !count_wr && !special_event_trig
		|=> $stable(count_reg)) // R4
		else $error("count moved while stopped");
	AST_INSTR_PERIOD: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick) // R3
		else $error("instruction tick period not four");
	AST_PIN_INPUTS: assert property (crystal_osc_enable
		|=> !osc_input_pin_oe && !osc_output_pin_oe) // R6
		else $error("oscillator pin driven with crystal on");
	AST_CTRL_UPPER: assert property (setup_phase && !pwrite && paddr == SBTC_ADDR_CTRL
		|=> prdata[31:6] == 26'h0000000) // R8
		else $error("control upper bits not zero");
	AST_ARM_FIRST: assert property ($rose(arm_reg == SBTC_ARM_READY) |-> $past(pin_fall)) // R11
		else $error("rising edge counted before falling edge");
	AST_SYNC_SLEEP: assert property (sleep_mode && !async_mode && !count_wr &&
		!special_event_trig |=> $stable(count_reg)) // R14
		else $error("count moved in sleep without async mode");
	AST_TRIG_CLEAR: assert property (special_event_trig && !count_wr
		|=> count_reg == SBTC_COUNT_ZERO && !ovf_event) // R22
		else $error("trigger did not clear count");
	AST_CTRL_KEEP: assert property (wr_access && paddr == SBTC_ADDR_CTRL && !advance &&
		!special_event_trig |=> $stable(count_reg)) // R26
		else $error("control write disturbed count");

	COV_OVERFLOW: cover property (ovf_event ##1 overflow_irq);
	COV_TRIGGER: cover property (special_event_trig && count_reg != SBTC_COUNT_ZERO);
	COV_ASYNC_SLEEP: cover property (async_mode && sleep_mode && advance);
	COV_WAKE: cover property (wake_request);

endmodule

// ---- dv/sbtc_ext_src.sv ----
// Purpose: external clock source on the far side of the counter pins
// Assumes: the bench routes the output to one pin at a time
// Notes: clock stands low between bursts, so no stray edges leak in
`timescale 1ns/1ps
module sbtc_ext_src (
	input wire logic pclk,
	output logic clk_out
);
	initial clk_out = 1'b0;
	// ----------------------------------------
	// burst of full pulses
	// ----------------------------------------
	// slow crystal-like pulses
	task burst(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge pclk);
			clk_out <= 1'b1;
			repeat (half) @(posedge pclk);
			clk_out <= 1'b0;
		end
	endtask
endmodule

// ---- dv/sbtc_bench.sv ----
// Purpose: self-checking bench for the sixteen bit timer/counter
// Assumes: zero wait APB slave, count read only while stopped or held in synchronised sleep
// Notes: timer counts are judged within one tick, phase of the divider is free
`timescale 1ns/1ps
module sbtc_bench;
	import sbtc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, erv, oi_oe, oo_oe, inv_en, irq, wake, tb_valid, src_clk;
	logic oi_out, oo_out;
	logic use_osc = 1'b0;
	logic sleep_mode = 1'b0;
	logic trig = 1'b0;
	logic [1:0] pdir = 2'b00;
	logic [15:0] tb_cnt, cnt, prev;
	int bad_count = 0;
	int checks = 0;

	always #2.5 pclk = ~pclk;

	sbtc_ext_src src (.pclk(pclk), .clk_out(src_clk));
	sbtc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.ext_clock_pin_in(use_osc ? 1'b0 : src_clk),
		.osc_input_pin_in(use_osc ? src_clk : 1'b0), .osc_input_pin_out(oi_out),
		.osc_input_pin_oe(oi_oe), .osc_output_pin_out(oo_out), .osc_output_pin_oe(oo_oe),
		.port_c_data(2'b10), .port_c_direction(pdir), .osc_inverter_en(inv_en),
		.sleep_mode(sleep_mode), .special_event_trig(trig), .overflow_irq(irq),
		.wake_request(wake), .timebase_valid(tb_valid), .timebase_count(tb_cnt));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %0t: got %h want %h", $time, s, e);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task set_cnt(input logic [15:0] v);
		apb(1'b1, SBTC_ADDR_COUNT_LO, {24'h0, v[7:0]});
		apb(1'b1, SBTC_ADDR_COUNT_HI, {24'h0, v[15:8]});
	endtask

	task rd_cnt;
		apb(1'b0, SBTC_ADDR_COUNT_LO, 32'h0);
		cnt[7:0] = rdv[7:0];
		apb(1'b0, SBTC_ADDR_COUNT_HI, 32'h0);
		cnt[15:8] = rdv[7:0];
	endtask

	task settle;
		repeat (4) @(posedge pclk);
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		apb(1'b0, SBTC_ADDR_CTRL, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, SBTC_ADDR_FLAG, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk({31'h0, erv}, 32'h1);
		settle;
		chk({30'h0, oi_oe, oo_oe}, 32'h3);
		chk({31'h0, inv_en}, 32'h0);
		@(posedge pclk);
		pdir <= 2'b01;
		settle;
		chk({30'h0, oi_oe, oo_oe}, 32'h2);
		chk({30'h0, oi_out, oo_out}, 32'h2);
		@(posedge pclk);
		pdir <= 2'b00;
		$display("reset test done");
	endtask

	task t_timer;
		for (int r = 0; r < 4; r++) begin
			set_cnt(16'h0000);
			apb(1'b1, SBTC_ADDR_CTRL, {26'h0, 2'(r), 4'h5});
			repeat (128) @(posedge pclk);
			apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
			rd_cnt;
			chk({31'h0, cnt >= (32 >> r) - 1 && cnt <= (32 >> r) + 1}, 32'h1);
			prev = cnt;
			repeat (20) @(posedge pclk);
			rd_cnt;
			chk({16'h0, cnt}, {16'h0, prev});
		end
		$display("timer test done");
	endtask

	task t_ctrl;
		apb(1'b1, SBTC_ADDR_CTRL, 32'hF0);
		apb(1'b0, SBTC_ADDR_CTRL, 32'h0);
		chk(rdv, 32'h30);
		rd_cnt;
		chk({16'h0, cnt}, {16'h0, prev});
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
		$display("control test done");
	endtask

	task t_counter;
		set_cnt(16'h0000);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h07);
		src.burst(5, 4);
		settle;
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
		rd_cnt;
		chk({16'h0, cnt}, 32'h4);
		use_osc <= 1'b1;
		set_cnt(16'h0000);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0F);
		settle;
		chk({30'h0, oi_oe, oo_oe}, 32'h0);
		chk({31'h0, inv_en}, 32'h1);
		src.burst(3, 4);
		settle;
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
		rd_cnt;
		chk({16'h0, cnt}, 32'h2);
		use_osc <= 1'b0;
		$display("counter test done");
	endtask

	task t_sleep;
		set_cnt(16'h0000);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h03);
		sleep_mode <= 1'b1;
		src.burst(5, 4);
		settle;
		rd_cnt;
		chk({16'h0, cnt}, 32'h0);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
		set_cnt(16'hFFFE);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h07);
		src.burst(4, 4);
		settle;
		chk({30'h0, tb_valid, irq}, 32'h0);
		apb(1'b1, SBTC_ADDR_ENABLE, 32'h1);
		#1;
		chk({30'h0, irq, wake}, 32'h3);
		apb(1'b1, SBTC_ADDR_CTRL, 32'h0);
		rd_cnt;
		chk({16'h0, cnt}, 32'h1);
		apb(1'b0, SBTC_ADDR_FLAG, 32'h0);
		chk(rdv, 32'h1);
		apb(1'b1, SBTC_ADDR_FLAG, 32'h0);
		#1;
		chk({31'h0, irq}, 32'h0);
		sleep_mode <= 1'b0;
		$display("sleep test done");
	endtask

	task t_trig;
		// trigger only used with the counter stopped, never in async mode
		set_cnt(16'h1234);
		@(posedge pclk);
		trig <= 1'b1;
		@(posedge pclk);
		trig <= 1'b0;
		rd_cnt;
		chk({16'h0, cnt}, 32'h0);
		apb(1'b0, SBTC_ADDR_FLAG, 32'h0);
		chk(rdv, 32'h0);
		#1;
		chk({15'h0, tb_valid, tb_cnt}, 32'h10000);
		@(posedge pclk);
		trig <= 1'b1;
		apb(1'b1, SBTC_ADDR_COUNT_LO, 32'h5A);
		trig <= 1'b0;
		rd_cnt;
		chk({16'h0, cnt}, 32'h5A);
		$display("trigger test done");
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_timer;
		t_ctrl;
		t_counter;
		t_sleep;
		t_trig;
		stop_test;
	end

	// whole run is near 1000 cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		stop_test;
	end
endmodule
